// >>> inc/pmrb_cfg.svh
// Register indices, field positions, reset values and timing for the bank
`ifndef PMRB_CFG_SVH
`define PMRB_CFG_SVH
`define PMRB_IDX_CTRL      5'h00
`define PMRB_IDX_STAT      5'h01
`define PMRB_IDX_IDH       5'h02
`define PMRB_IDX_IDL       5'h03
`define PMRB_IDX_ADV       5'h04
`define PMRB_IDX_LPA       5'h05
`define PMRB_IDX_EXP       5'h06
`define PMRB_IDX_MODE      5'h11
`define PMRB_IDX_SPMODE    5'h12
`define PMRB_IDX_SYMERR    5'h1A
`define PMRB_IDX_CSIND     5'h1B
`define PMRB_IDX_ISRC      5'h1D
`define PMRB_IDX_IMASK     5'h1E
`define PMRB_IDX_SPCS      5'h1F
`define PMRB_CTRL_RST_BIT  15
`define PMRB_CTRL_RAN_BIT  9
`define PMRB_CTRL_WMASK    16'hFF00
`define PMRB_CTRL_RESET    16'h3100
`define PMRB_STAT_FIXED    16'h7809
`define PMRB_STAT_RF_BIT   4
`define PMRB_STAT_LINK_BIT 2
`define PMRB_STAT_JAB_BIT  1
`define PMRB_IDH_RESET     16'h0007
`define PMRB_IDL_RESET     16'hC0F0
`define PMRB_ADV_RESET     16'h01E1
`define PMRB_ADV_WMASK     16'h2DFF
`define PMRB_MODE_RESET    16'h0002
`define PMRB_MODE_WMASK    16'h2242
`define PMRB_SPMODE_RESET  16'h40E0
`define PMRB_SPMODE_WMASK  16'h40FF
`define PMRB_CSIND_RESET   16'h0000
`define PMRB_CSIND_WMASK   16'hA810
`define PMRB_IMASK_WMASK   16'h00FE
`define PMRB_SPCS_RESET    16'h0040
`define PMRB_SPCS_WMASK    16'h0040
`define PMRB_AN_TIME_NS    2000
`define PMRB_AN_CYCLES     (`PMRB_AN_TIME_NS / 40)
`define PMRB_RST_TIME_NS   400
`define PMRB_RST_CYCLES    (`PMRB_RST_TIME_NS / 40)
`endif

// >>> inc/pmrb_pkg.sv
// Types shared by the management register bank
package pmrb_pkg;
   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [4:0]  idx;
      logic [15:0] wdata;
   } pmrb_req_t;
   typedef struct packed {
      logic remote_fault;
      logic link_up;
      logic jabber;
      logic an_done;
      logic sym_err;
      logic [15:0] partner_ability;
      logic [7:0]  irq_events;
   } pmrb_stat_t;
   typedef enum logic [1:0] {
      PMRB_S_IDLE,
      PMRB_S_SOFTRST,
      PMRB_S_ANRST
   } pmrb_state_t;
endpackage : pmrb_pkg

// >>> rtl/pmrb_latch.sv
// One read-only status bit that latches high or low until the register is read
`timescale 1ns/1ns
`default_nettype none
module pmrb_latch #(
   parameter bit LATCH_HIGH = 1'b1
) (
   // Clock and reset
   input  wire logic clk,
   input  wire logic rst_n,
   input  wire logic soft_rst,
   // Condition and read strobe
   input  wire logic cond,
   input  wire logic rd_stb,
   output logic      bit_q
);
   logic armed_q;
   logic armed_d;
   // Latched value stays until its register is read, then follows cond
   wire held    = LATCH_HIGH ? (armed_q | cond) : (armed_q ? 1'b0 : cond);
   wire trigger = LATCH_HIGH ? cond : ~cond;
   assign bit_q = held;
   // Set wins over the read release so an event in the read cycle survives
   assign armed_d = trigger ? 1'b1 : (rd_stb ? 1'b0 : armed_q);
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         armed_q <= LATCH_HIGH ? 1'b0 : 1'b1;
      end else if (soft_rst) begin
         armed_q <= LATCH_HIGH ? 1'b0 : 1'b1;
      end else begin
         armed_q <= armed_d;   // see RL9 see RL10
      end
   end
endmodule : pmrb_latch
`default_nettype wire

// >>> rtl/pmrb_sync.sv
// Two-flop synchroniser for a bundle of status levels
`timescale 1ns/1ns
`default_nettype none
module pmrb_sync #(
   parameter int W = 1
) (
   // Clock and reset
   input  wire logic         clk,
   input  wire logic         rst_n,
   // Asynchronous levels in, synchronised copies out
   input  wire logic [W-1:0] d,
   output logic [W-1:0]      q
);
   logic [W-1:0] meta_q;
   // First stage feeds only the second stage
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_q <= '0;
         q      <= '0;
      end else begin
         meta_q <= d;
         q      <= meta_q;
      end
   end
endmodule : pmrb_sync
`default_nettype wire

// >>> rtl/pmrb_bank.sv
// Management register bank of a 10/100 transceiver
`timescale 1ns/1ns
`default_nettype none
`include "pmrb_cfg.svh"
// Summary of operation
// RL1: Clause 22 registers selected by decimal index
// RL2: Read-only bits ignore writes, reads current
// RL3: Host ignores data read from write-only bits
// RL4: Write one clears bit, zero keeps
// RL5: Any write to bit clears it
// RL6: Read returns contents then clears; writes ignored
// RL7: Written one clears itself; zero ignored
// RL8: Cleared bit sets itself; one ignored
// RL9: Latched-high holds until read, then follows
// RL10: Latched-low holds zero until register read
// RL11: Kept bits survive soft reset, others default
// RL12: Host writes reserved zero, ignores reads
// RL13: Read-write bits store and read back
// RL14: Advertise, partner, expansion at 4, 5, 6
// RL15: Symbol error counter at index 26
// RL16: Control and status indication at 27
// RL17: Special control and status at 31
// RL18: Main control is 16-bit at index 0
// RL19: Unmapped indices read zero, ignore writes
module pmrb_bank (
   // Clock and reset
   input  wire logic               clk,
   input  wire logic               reset_n,
   // Management access from the serial port decoder
   input  wire pmrb_pkg::pmrb_req_t req,
   output logic [15:0]             rdata_q,
   output logic                    rvalid_q,
   // Line-side status, asynchronous to clk
   input  wire pmrb_pkg::pmrb_stat_t line_stat,
   // Control outputs to the transceiver core
   output logic [15:0]             ctrl_q,
   output logic [15:0]             mode_q,
   output logic [15:0]             spmode_q,
   output logic [15:0]             csind_q,
   output logic [15:0]             imask_q,
   output logic [15:0]             spcs_q,
   output logic [15:0]             adv_q,
   output logic                    irq_n
);
   localparam int SW = 29;
   logic rst_a_q;
   logic rst_b_q;
   logic rst_n;
   logic [SW-1:0] st_sync;
   pmrb_pkg::pmrb_stat_t st;
   pmrb_pkg::pmrb_state_t state_q;
   pmrb_pkg::pmrb_state_t state_d;
   logic [7:0]  cnt_q;
   logic [7:0]  cnt_d;
   logic [15:0] idh_q;
   logic [15:0] idl_q;
   logic [15:0] lpa_q;
   logic [15:0] symerr_q;
   logic [15:0] symerr_d;
   logic [7:0]  isrc_q;
   logic [7:0]  isrc_d;
   logic        pdf_q;
   logic        rf_bit;
   logic        link_bit;
   logic        jab_bit;
   logic [15:0] rdata_d;

   // Reset release through two flops, assertion stays asynchronous
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rst_a_q <= 1'b0;
         rst_b_q <= 1'b0;
      end else begin
         rst_a_q <= 1'b1;
         rst_b_q <= rst_a_q;
      end
   end
   assign rst_n = rst_b_q;

   // Line status crosses in through two flops before anything reads it
   pmrb_sync #(.W(SW)) u_sync (
      .clk   (clk),
      .rst_n (rst_n),
      .d     (line_stat),
      .q     (st_sync)
   );
   assign st = pmrb_pkg::pmrb_stat_t'(st_sync);

   // Access decode
   wire wr = req.wr;
   wire rd = req.rd;
   wire [4:0] ix = req.idx;
   wire [15:0] wd = req.wdata;
   wire hit_ctrl   = (ix == `PMRB_IDX_CTRL);    // see RL18
   wire hit_stat   = (ix == `PMRB_IDX_STAT);
   wire hit_idh    = (ix == `PMRB_IDX_IDH);
   wire hit_idl    = (ix == `PMRB_IDX_IDL);
   wire hit_adv    = (ix == `PMRB_IDX_ADV);     // see RL14
   wire hit_lpa    = (ix == `PMRB_IDX_LPA);     // see RL14
   wire hit_exp    = (ix == `PMRB_IDX_EXP);     // see RL14
   wire hit_mode   = (ix == `PMRB_IDX_MODE);
   wire hit_spmode = (ix == `PMRB_IDX_SPMODE);
   wire hit_symerr = (ix == `PMRB_IDX_SYMERR);  // see RL15
   wire hit_csind  = (ix == `PMRB_IDX_CSIND);   // see RL16
   wire hit_isrc   = (ix == `PMRB_IDX_ISRC);
   wire hit_imask  = (ix == `PMRB_IDX_IMASK);
   wire hit_spcs   = (ix == `PMRB_IDX_SPCS);    // see RL17
   wire soft_rst   = (state_q == pmrb_pkg::PMRB_S_SOFTRST);
   wire rd_stat    = rd & hit_stat;
   wire rd_exp     = rd & hit_exp;

   // Self-clearing control bits: sequencer holds them until done
   wire go_rst = wr & hit_ctrl & wd[`PMRB_CTRL_RST_BIT];
   wire go_an  = wr & hit_ctrl & wd[`PMRB_CTRL_RAN_BIT];
   always_comb begin
      state_d = state_q;
      cnt_d   = cnt_q;
      case (state_q)
         pmrb_pkg::PMRB_S_IDLE: begin
            if (go_rst) begin
               state_d = pmrb_pkg::PMRB_S_SOFTRST;
               cnt_d   = 8'(`PMRB_RST_CYCLES - 1);
            end else if (go_an) begin
               state_d = pmrb_pkg::PMRB_S_ANRST;
               cnt_d   = 8'(`PMRB_AN_CYCLES - 1);
            end
         end
         pmrb_pkg::PMRB_S_SOFTRST, pmrb_pkg::PMRB_S_ANRST: begin
            if (cnt_q == 8'h00) begin
               state_d = pmrb_pkg::PMRB_S_IDLE;   // see RL7
            end else begin
               cnt_d = cnt_q - 8'h01;
            end
         end
         default: state_d = pmrb_pkg::PMRB_S_IDLE;
      endcase
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= pmrb_pkg::PMRB_S_IDLE;
         cnt_q   <= 8'h00;
      end else begin
         state_q <= state_d;
         cnt_q   <= cnt_d;
      end
   end

   // Ordinary read-write storage; writes during soft reset are dropped
   wire wr_ok = wr & ~soft_rst;
   function automatic logic [15:0] rw_merge(input logic [15:0] old,
                                            input logic [15:0] nw,
                                            input logic [15:0] m);
      rw_merge = (old & ~m) | (nw & m);
   endfunction
   wire [15:0] ctrl_store = {1'b0, ctrl_q[14:10], 1'b0, ctrl_q[8:0]};
   // Main control: self-clearing bits follow the sequencer's next state, but soft reset holds bit 15 set through its last cycle
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_q <= `PMRB_CTRL_RESET;
      end else if (soft_rst) begin
         ctrl_q <= `PMRB_CTRL_RESET | 16'h8000;   // see RL11
      end else begin
         ctrl_q <= {state_d == pmrb_pkg::PMRB_S_SOFTRST, ctrl_store[14:10],
                    state_d == pmrb_pkg::PMRB_S_ANRST, ctrl_store[8:0]};
         if (wr_ok & hit_ctrl) begin
            ctrl_q[14:10] <= wd[14:10];   // see RL13
            ctrl_q[8]     <= wd[8];
         end
      end
   end

   // Other read-write registers fall back to defaults on soft reset
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         adv_q   <= `PMRB_ADV_RESET;
         mode_q  <= `PMRB_MODE_RESET;
         csind_q <= `PMRB_CSIND_RESET;
         imask_q <= 16'h0000;
      end else if (soft_rst) begin
         adv_q   <= `PMRB_ADV_RESET;   // see RL11
         mode_q  <= `PMRB_MODE_RESET;
         csind_q <= `PMRB_CSIND_RESET;
         imask_q <= 16'h0000;
      end else begin
         if (wr_ok & hit_adv) begin
            adv_q <= rw_merge(adv_q, wd, `PMRB_ADV_WMASK);
         end
         if (wr_ok & hit_mode) begin
            mode_q <= rw_merge(mode_q, wd, `PMRB_MODE_WMASK);
         end
         if (wr_ok & hit_csind) begin
            csind_q <= rw_merge(csind_q, wd, `PMRB_CSIND_WMASK);
         end
         if (wr_ok & hit_imask) begin
            imask_q <= rw_merge(imask_q, wd, `PMRB_IMASK_WMASK);
         end
      end
   end

   // Identifier words are kept on soft reset; only a hard reset loads them
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         idh_q <= `PMRB_IDH_RESET;
         idl_q <= `PMRB_IDL_RESET;
      end else begin
         if (wr_ok & hit_idh) begin
            idh_q <= wd;   // see RL13
         end
         if (wr_ok & hit_idl) begin
            idl_q <= wd;
         end
      end
   end

   // Kept-on-soft-reset registers: only the hard reset touches them
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         spmode_q <= `PMRB_SPMODE_RESET;
         spcs_q   <= `PMRB_SPCS_RESET;
      end else begin
         if (wr_ok & hit_spmode) begin
            spmode_q <= rw_merge(spmode_q, wd, `PMRB_SPMODE_WMASK); // see RL11
         end
         if (wr_ok & hit_spcs) begin
            spcs_q <= rw_merge(spcs_q, wd, `PMRB_SPCS_WMASK);
         end
      end
   end

   // Partner ability is read-only: sampled from the line, never written
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         lpa_q <= 16'h0000;
      end else begin
         lpa_q <= soft_rst ? 16'h0000 : st.partner_ability;   // see RL2
      end
   end

   // Expansion page-received flag: set by negotiation done, cleared by reading
   wire pdf_d = st.an_done ? 1'b1 : (rd_exp ? 1'b0 : pdf_q);
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pdf_q <= 1'b0;
      end else begin
         pdf_q <= soft_rst ? 1'b0 : pdf_d;   // see RL9
      end
   end

   // Symbol errors count up, the read returns the count then clears it
   always_comb begin
      symerr_d = symerr_q;
      if (rd & hit_symerr) begin
         symerr_d = 16'h0000;   // see RL6
      end
      if (st.sym_err && (symerr_d != 16'hFFFF)) begin
         symerr_d = symerr_d + 16'h0001;   // Event beats the clear
      end
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         symerr_q <= 16'h0000;
      end else begin
         symerr_q <= soft_rst ? 16'h0000 : symerr_d;
      end
   end

   // No bit of this map is write-one-clear, write-anything-clear or
   // self-setting, so those attributes have no storage of their own
   // see RL4 see RL5 see RL8
   // Event source bits are read-to-clear; new events win over the clear
   genvar g;
   generate
      for (g = 0; g < 8; g++) begin : g_isrc
         assign isrc_d[g] = st.irq_events[g] |
                            (isrc_q[g] & ~(rd & hit_isrc));   // see RL6
      end
   endgenerate
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         isrc_q <= 8'h00;
      end else begin
         isrc_q <= soft_rst ? 8'h00 : isrc_d;
      end
   end
   assign irq_n = ~|(isrc_q & imask_q[7:0]);

   // Latched status bits of the main status register
   pmrb_latch #(.LATCH_HIGH(1'b1)) u_rf (
      .clk      (clk),
      .rst_n    (rst_n),
      .soft_rst (soft_rst),
      .cond     (st.remote_fault),
      .rd_stb   (rd_stat),
      .bit_q    (rf_bit)
   );
   pmrb_latch #(.LATCH_HIGH(1'b0)) u_link (
      .clk      (clk),
      .rst_n    (rst_n),
      .soft_rst (soft_rst),
      .cond     (st.link_up),
      .rd_stb   (rd_stat),
      .bit_q    (link_bit)
   );
   pmrb_latch #(.LATCH_HIGH(1'b1)) u_jab (
      .clk      (clk),
      .rst_n    (rst_n),
      .soft_rst (soft_rst),
      .cond     (st.jabber),
      .rd_stb   (rd_stat),
      .bit_q    (jab_bit)
   );
   wire [15:0] stat_word = `PMRB_STAT_FIXED |
                           {10'h000, st.an_done, rf_bit, 1'b0,
                            link_bit, jab_bit, 1'b0};

   // Read mux by index; unmapped indices read zero
   always_comb begin
      case (ix)   // see RL1
         `PMRB_IDX_CTRL:   rdata_d = ctrl_q;
         `PMRB_IDX_STAT:   rdata_d = stat_word;
         `PMRB_IDX_IDH:    rdata_d = idh_q;
         `PMRB_IDX_IDL:    rdata_d = idl_q;
         `PMRB_IDX_ADV:    rdata_d = adv_q;
         `PMRB_IDX_LPA:    rdata_d = lpa_q;
         `PMRB_IDX_EXP:    rdata_d = {14'h0000, pdf_q, 1'b0};
         `PMRB_IDX_MODE:   rdata_d = mode_q;
         `PMRB_IDX_SPMODE: rdata_d = spmode_q;
         `PMRB_IDX_SYMERR: rdata_d = symerr_q;
         `PMRB_IDX_CSIND:  rdata_d = csind_q;
         `PMRB_IDX_ISRC:   rdata_d = {8'h00, isrc_q};
         `PMRB_IDX_IMASK:  rdata_d = imask_q;
         `PMRB_IDX_SPCS:   rdata_d = spcs_q;
         default:          rdata_d = 16'h0000;   // see RL19
      endcase
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rdata_q  <= 16'h0000;
         rvalid_q <= 1'b0;
      end else begin
         rdata_q  <= rd ? rdata_d : rdata_q;
         rvalid_q <= rd;
      end
   end
endmodule : pmrb_bank
`default_nettype wire

// >>> dv/pmrb_bank_properties.sv
// Port-level assertions for the management register bank
`timescale 1ns/1ns
`default_nettype none
`include "pmrb_cfg.svh"
module pmrb_bank_checker (
   // Clock and reset
   input wire logic                 clk,
   input wire logic                 reset_n,
   // Management access
   input wire pmrb_pkg::pmrb_req_t  req,
   input wire logic [15:0]          rdata_q,
   input wire logic                 rvalid_q,
   // Line status and register contents
   input wire pmrb_pkg::pmrb_stat_t line_stat,
   input wire logic [15:0]          ctrl_q,
   input wire logic [15:0]          mode_q,
   input wire logic [15:0]          spmode_q,
   input wire logic [15:0]          csind_q,
   input wire logic [15:0]          imask_q,
   input wire logic [15:0]          spcs_q,
   input wire logic [15:0]          adv_q,
   input wire logic                 irq_n
);
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);
   // Read answer comes one cycle later and data holds between reads
   a_read_answer: assert property (req.rd |=> rvalid_q)
      else $error("no answer after read");
   a_answer_cause: assert property (rvalid_q |-> $past(req.rd))
      else $error("answer without read");
   a_rdata_hold: assert property (!rvalid_q |-> $stable(rdata_q))
      else $error("read data moved between reads");
   // Writable masks; soft reset blocks writes, so only outside it
   a_adv_write: assert property (req.wr && req.idx == 5'h04 && !ctrl_q[15]
      |=> adv_q == (($past(req.wdata) & `PMRB_ADV_WMASK)
         | ($past(adv_q) & ~`PMRB_ADV_WMASK)))
      else $error("advertise write wrong");
   a_imask_write: assert property (req.wr && req.idx == 5'h1E && !ctrl_q[15]
      |=> imask_q == ($past(req.wdata) & `PMRB_IMASK_WMASK))
      else $error("mask write wrong");
   a_hole_write: assert property (req.wr && req.idx == 5'h07
      |=> $stable(ctrl_q) && $stable(adv_q) && $stable(mode_q))
      else $error("unmapped write changed state");
   a_ctrl_reserved: assert property (ctrl_q[7:0] == 8'h00)
      else $error("reserved control bits set");
   // Self-clearing bits drop within a bounded time
   a_soft_clear: assert property ($rose(ctrl_q[15])
      |-> ctrl_q[15] [*8] ##[1:4] !ctrl_q[15])
      else $error("soft reset bit length wrong");
   a_an_clear: assert property (ctrl_q[9] |-> ##[1:60] !ctrl_q[9])
      else $error("restart bit stuck");
   // Soft reset keeps flagged registers and restores the rest
   a_kept_regs: assert property (ctrl_q[15]
      |-> $stable(spmode_q) && $stable(spcs_q))
      else $error("kept register changed in soft reset");
   a_soft_dflt: assert property ($fell(ctrl_q[15])
      |-> ctrl_q == `PMRB_CTRL_RESET && adv_q == `PMRB_ADV_RESET
         && mode_q == `PMRB_MODE_RESET)
      else $error("defaults missing after soft reset");
endmodule : pmrb_bank_checker
bind pmrb_bank pmrb_bank_checker u_chk (
   .clk(clk), .reset_n(reset_n), .req(req), .rdata_q(rdata_q),
   .rvalid_q(rvalid_q), .line_stat(line_stat), .ctrl_q(ctrl_q),
   .mode_q(mode_q), .spmode_q(spmode_q), .csind_q(csind_q),
   .imask_q(imask_q), .spcs_q(spcs_q), .adv_q(adv_q), .irq_n(irq_n)
);
`default_nettype wire

// >>> dv/pmrb_host_model.sv
// Station management controller model issuing single-cycle requests
`timescale 1ns/1ns
`default_nettype none
module pmrb_host_model (
   // Clock
   input wire logic                 clk,
   // Answer from the bank
   input wire logic [15:0]          rdata_q,
   input wire logic                 rvalid_q,
   // Request to the bank
   output var pmrb_pkg::pmrb_req_t  req
);
   // Idle request from time zero
   initial req = '0;
   // Write strobe stands across exactly one rising edge
   task automatic wr(input logic [4:0] i, input logic [15:0] d);
      @(negedge clk);
      req.wr = 1'b1;
      req.idx = i;
      req.wdata = (i == 5'h00) ? {d[15:8], 8'h00} : d;
      @(negedge clk);
      req = '0;
   endtask : wr
   // Data is trusted only with the answer strobe, so a lost one shows
   task automatic rd(input logic [4:0] i, output logic [15:0] d);
      @(negedge clk);
      req.rd = 1'b1;
      req.idx = i;
      @(negedge clk);
      req = '0;
      d = (rvalid_q === 1'b1) ? rdata_q : 16'hXXXX;
   endtask : rd
endmodule : pmrb_host_model
`default_nettype wire

// >>> dv/phy_mgmt_register_bank_tb.sv
// Self-checking bench for the management register bank
`timescale 1ns/1ns
`default_nettype none
`include "pmrb_cfg.svh"
module phy_mgmt_register_bank_tb;
   logic                 clk = 1'b0;
   logic                 reset_n = 1'b0;
   pmrb_pkg::pmrb_stat_t line_stat = '0;
   pmrb_pkg::pmrb_req_t  req;
   logic [15:0]          rdata_q, ctrl_q, mode_q, spmode_q, v;
   logic [15:0]          csind_q, imask_q, spcs_q, adv_q;
   logic                 rvalid_q, irq_n;
   int                   n_errors = 0;
   int                   checks = 0;
   // 25 MHz clock
   always #20 clk = ~clk;
   pmrb_bank dut (.clk(clk), .reset_n(reset_n), .req(req),
      .rdata_q(rdata_q), .rvalid_q(rvalid_q), .line_stat(line_stat),
      .ctrl_q(ctrl_q), .mode_q(mode_q), .spmode_q(spmode_q),
      .csind_q(csind_q), .imask_q(imask_q), .spcs_q(spcs_q),
      .adv_q(adv_q), .irq_n(irq_n));
   pmrb_host_model host (.clk(clk), .rdata_q(rdata_q),
      .rvalid_q(rvalid_q), .req(req));
   task automatic summarize;
      if (n_errors == 0 && checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : summarize
   task automatic chk(input string nm, input logic [15:0] e,
                      input logic [15:0] g);
      checks++;
      if (g !== e) begin
         n_errors++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic rdchk(input string nm, input logic [4:0] i,
                        input logic [15:0] e);
      host.rd(i, v);
      chk(nm, e, v);
   endtask : rdchk
   // Every mapped index at its reset value, partner ability at the line's A5C3, a hole reads zero
   task automatic t_map;
      rdchk("ctrl", 5'd0, `PMRB_CTRL_RESET);
      rdchk("stat", 5'd1, `PMRB_STAT_FIXED);
      rdchk("idh", 5'd2, `PMRB_IDH_RESET);
      rdchk("idl", 5'd3, `PMRB_IDL_RESET);
      rdchk("adv", 5'd4, `PMRB_ADV_RESET);
      rdchk("lpa", 5'd5, 16'hA5C3);
      rdchk("exp", 5'd6, 16'h0000);
      rdchk("mode", 5'd17, `PMRB_MODE_RESET);
      rdchk("spmode", 5'd18, `PMRB_SPMODE_RESET);
      rdchk("symerr", 5'd26, 16'h0000);
      rdchk("csind", 5'd27, `PMRB_CSIND_RESET);
      rdchk("isrc", 5'd29, 16'h0000);
      rdchk("imask", 5'd30, 16'h0000);
      rdchk("spcs", 5'd31, `PMRB_SPCS_RESET);
      rdchk("hole", 5'd7, 16'h0000);
   endtask : t_map
   // Masked writes, a read-only write and an unmapped write
   task automatic t_rw;
      host.wr(5'd4, 16'hFFFF);
      rdchk("adv rw", 5'd4, `PMRB_ADV_WMASK);
      host.wr(5'd30, 16'hFFFF);
      rdchk("imask rw", 5'd30, `PMRB_IMASK_WMASK);
      chk("adv out", `PMRB_ADV_WMASK, adv_q);
      chk("imask out", `PMRB_IMASK_WMASK, imask_q);
      host.wr(5'd27, 16'hFFFF);
      rdchk("csind rw", 5'd27, `PMRB_CSIND_WMASK);
      chk("csind out", `PMRB_CSIND_WMASK, csind_q);
      host.wr(5'd1, 16'h0000);
      rdchk("stat ro", 5'd1, `PMRB_STAT_FIXED);
      host.wr(5'd7, 16'hFFFF);
      rdchk("hole wr", 5'd7, 16'h0000);
   endtask : t_rw
   // Link dip held low; fault and jabber pulses held high until read
   task automatic t_latch;
      line_stat.link_up = 1'b1;
      repeat (6) @(negedge clk);
      rdchk("link low", 5'd1, `PMRB_STAT_FIXED);
      rdchk("link up", 5'd1, `PMRB_STAT_FIXED | 16'h0004);
      line_stat.link_up = 1'b0;
      repeat (4) @(negedge clk);
      line_stat.link_up = 1'b1;
      line_stat.remote_fault = 1'b1;
      line_stat.jabber = 1'b1;
      repeat (4) @(negedge clk);
      line_stat.remote_fault = 1'b0;
      line_stat.jabber = 1'b0;
      repeat (4) @(negedge clk);
      rdchk("held", 5'd1, `PMRB_STAT_FIXED | 16'h0012);
      rdchk("freed", 5'd1, `PMRB_STAT_FIXED | 16'h0004);
   endtask : t_latch
   // Negotiation done shows live in status and latches expansion bit 1
   task automatic t_an;
      line_stat.an_done = 1'b1;
      repeat (4) @(negedge clk);
      rdchk("an live", 5'd1, `PMRB_STAT_FIXED | 16'h0024);
      rdchk("exp set", 5'd6, 16'h0002);
      line_stat.an_done = 1'b0;
      repeat (4) @(negedge clk);
      rdchk("exp held", 5'd6, 16'h0002);
      rdchk("exp clr", 5'd6, 16'h0000);
      rdchk("an gone", 5'd1, `PMRB_STAT_FIXED | 16'h0004);
   endtask : t_an
   // Counter and event source return contents then clear; writes ignored
   task automatic t_rclr;
      line_stat.sym_err = 1'b1;
      line_stat.irq_events = 8'h0A;
      repeat (5) @(negedge clk);
      line_stat.sym_err = 1'b0;
      line_stat.irq_events = 8'h00;
      repeat (4) @(negedge clk);
      chk("irq_n", 16'h0000, {15'h0000, irq_n});
      host.wr(5'd26, 16'h0000);
      host.wr(5'd29, 16'h0000);
      rdchk("symerr", 5'd26, 16'h0005);
      rdchk("symerr clr", 5'd26, 16'h0000);
      rdchk("isrc", 5'd29, 16'h000A);
      rdchk("isrc clr", 5'd29, 16'h0000);
   endtask : t_rclr
   // Soft reset with a write landing inside it
   task automatic t_soft;
      host.wr(5'd18, 16'h4011);
      host.wr(5'd17, 16'h0040);
      chk("mode wr", 16'h0040, mode_q);
      host.wr(5'd31, 16'h0000);
      host.wr(5'd3, 16'h5A5A);
      host.wr(5'd0, 16'h8000);
      host.wr(5'd4, 16'h0000);
      for (int i = 0; i < 40 && ctrl_q[15] !== 1'b0; i++) @(negedge clk);
      chk("soft end", 16'h0000, {15'h0000, ctrl_q[15]});
      rdchk("ctrl dflt", 5'd0, `PMRB_CTRL_RESET);
      rdchk("adv dflt", 5'd4, `PMRB_ADV_RESET);
      rdchk("mode dflt", 5'd17, `PMRB_MODE_RESET);
      rdchk("imask dflt", 5'd30, 16'h0000);
      rdchk("spmode kept", 5'd18, 16'h4011);
      rdchk("spcs kept", 5'd31, 16'h0000);
      rdchk("idl kept", 5'd3, 16'h5A5A);
      rdchk("csind dflt", 5'd27, `PMRB_CSIND_RESET);
      chk("mode out", `PMRB_MODE_RESET, mode_q);
      chk("spcs out", 16'h0000, spcs_q);
      chk("spmode out", 16'h4011, spmode_q);
   endtask : t_soft
   // Restart bit clears itself; host model zeroes the low byte of a control write, so 31FF reaches the bank as 3100
   task automatic t_restart;
      host.wr(5'd0, 16'h3300);
      rdchk("restart", 5'd0, 16'h3300);
      repeat (`PMRB_AN_CYCLES + 5) @(negedge clk);
      rdchk("restart clr", 5'd0, 16'h3100);
      host.wr(5'd0, 16'h31FF);
      rdchk("ctrl low", 5'd0, 16'h3100);
   endtask : t_restart
   // Main sequence
   initial begin
      line_stat.partner_ability = 16'hA5C3;
      repeat (12) @(negedge clk);
      reset_n = 1'b1;
      repeat (3) @(negedge clk);
      t_map();
      t_rw();
      t_latch();
      t_an();
      t_rclr();
      t_soft();
      t_restart();
      summarize();
   end
   // Hang guard, about 50k cycles
   initial begin
      #2000000;
      n_errors++;
      summarize();
   end
endmodule : phy_mgmt_register_bank_tb
`default_nettype wire
